// >>> urm_pkg.sv
// Constants and carrier types shared by the UART channel register map.
package urm_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SPR = 3'h7;

    // ----------------------------------------------------------------
    // Codes, field positions and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] LCR_ENH_CODE = 8'hbf;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam int LCR_DIV_EN_BIT = 7;
    localparam int EFR_UNLOCK_BIT = 4;
    localparam int FCR_FIFO_EN_BIT = 0;
    localparam int IER_RX_BIT = 0;
    localparam int IER_TX_BIT = 1;
    localparam int IER_LS_BIT = 2;
    localparam int IER_MS_BIT = 3;
    localparam logic [7:0] IER_BASE_MASK = 8'h0f;
    localparam logic [7:0] ISR_BASE_MASK = 8'hcf;
    localparam logic [7:0] FCR_BASE_MASK = 8'hcf;
    localparam logic [7:0] MCR_BASE_MASK = 8'h1f;
    localparam logic [7:0] FRAC_MASK = 8'h3f;
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [3:0] ISR_LS_CODE = 4'h6;
    localparam logic [3:0] ISR_RX_CODE = 4'h4;
    localparam logic [3:0] ISR_TX_CODE = 4'h2;
    localparam logic [3:0] ISR_MS_CODE = 4'h0;
    // Arbitrary identity values, not tied to any real part.
    localparam logic [7:0] REVISION_CODE = 8'h01;
    localparam logic [7:0] DEVICE_IDENT = 8'h5a;

    // ----------------------------------------------------------------
    // Receive FIFO sizing and trigger levels
    // ----------------------------------------------------------------
    localparam int RX_DEPTH = 16;
    localparam int RX_AW = 4;
    localparam logic [RX_AW:0] TRIG_L0 = 5'h01;
    localparam logic [RX_AW:0] TRIG_L1 = 5'h04;
    localparam logic [RX_AW:0] TRIG_L2 = 5'h08;
    localparam logic [RX_AW:0] TRIG_L3 = 5'h0e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic [2:0] err;
    } urm_rx_word_t;

    typedef struct packed {
        logic carrier_detect_n;
        logic ring_indicator_n;
        logic dsr_n;
        logic cts_n;
    } urm_modem_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } urm_acc_t;

endpackage

// >>> urm_mem.sv
// Small receive word store with registered read data.
`timescale 1ns/1ps
`default_nettype none
module urm_mem (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire urm_pkg::urm_rx_word_t i_wdata,
    input wire logic [3:0] i_raddr,
    output var urm_pkg::urm_rx_word_t o_rdata
);
    urm_pkg::urm_rx_word_t mem_q [urm_pkg::RX_DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        // Write-first, so a word pushed into an empty queue is readable at once.
        if (i_we && i_waddr == i_raddr) begin
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem_q[i_raddr];
        end
    end
endmodule
`default_nettype wire

// >>> urm_rxq.sv
// Receive FIFO bookkeeping: pointers, fill count and storage.
`timescale 1ns/1ps
`default_nettype none
module urm_rxq (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clr,
    input wire logic i_push,
    input wire urm_pkg::urm_rx_word_t i_word,
    input wire logic i_pop,
    output var urm_pkg::urm_rx_word_t o_head,
    output logic [urm_pkg::RX_AW:0] o_count
);
    logic [urm_pkg::RX_AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [urm_pkg::RX_AW:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    // A push into a full queue is dropped; the caller flags overrun.
    assign do_push = i_push && (cnt_q != 5'(urm_pkg::RX_DEPTH));
    assign do_pop = i_pop && (cnt_q != '0);

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (i_clr) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end else begin
            if (do_push) wp_d = wp_q + 1'b1;
            if (do_pop) rp_d = rp_q + 1'b1;
            if (do_push && !do_pop) cnt_d = cnt_q + 1'b1;
            if (do_pop && !do_push) cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Read address looks ahead so the head word is ready after a pop.
    urm_mem u_mem (
        .i_clk(i_clk),
        .i_we(do_push),
        .i_waddr(wp_q),
        .i_wdata(i_word),
        .i_raddr(rp_d),
        .o_rdata(o_head)
    );

    assign o_count = cnt_q;
endmodule
`default_nettype wire

// >>> urm_regs.sv
// Channel register map of a UART with receive trigger interrupt.
`timescale 1ns/1ps
`default_nettype none
module urm_regs (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_irq,
    input wire logic i_rx_push,
    input wire urm_pkg::urm_rx_word_t i_rx_word,
    input wire logic i_tx_hold_empty,
    input wire logic i_tx_all_empty,
    input wire urm_pkg::urm_modem_t i_modem_n,
    output logic [7:0] o_tx_data,
    output logic o_tx_load,
    output logic [15:0] o_divisor,
    output logic [7:0] o_frac,
    output logic [7:0] o_efr,
    output logic [7:0] o_lcr,
    output logic [7:0] o_mcr
);
    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    urm_pkg::urm_modem_t m1_q, m2_q, m3_q;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            m1_q <= '1;
            m2_q <= '1;
            m3_q <= '1;
        end else begin
            m1_q <= i_modem_n;
            m2_q <= m1_q;
            m3_q <= m2_q;
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic [7:0] lcr_q, lcr_d, ier_q, ier_d, fcr_q, fcr_d, mcr_q, mcr_d;
    logic [7:0] dll_q, dll_d, dlm_q, dlm_d, frac_q, frac_d, efr_q, efr_d;
    logic [7:0] spr_q, spr_d, rdata_q, rdata_d;
    logic [7:0] resume_char_one_reg_q, resume_char_one_reg_d, resume_char_two_reg_q, resume_char_two_reg_d;
    logic [7:0] pause_char_one_reg_q, pause_char_one_reg_d, pause_char_two_reg_q, pause_char_two_reg_d;
    logic [3:0] dmsr_q, dmsr_d;
    logic ovr_q, ovr_d, unlock;
    logic enh_view, div_view, id_view, rx_clr, rx_pop;
    urm_pkg::urm_acc_t acc;
    urm_pkg::urm_rx_word_t head;
    logic [urm_pkg::RX_AW:0] fill, trig;
    logic [7:0] line_status_reg, modem_status_reg, irq_status_reg;
    logic trig_hit, rx_src, ls_src, tx_src, ms_src;

    function automatic logic [7:0] merge_locked(input logic [7:0] old_v,
            input logic [7:0] new_v, input logic [7:0] base, input logic ul);
        logic [7:0] m;
        m = ul ? 8'hff : base;
        merge_locked = (new_v & m) | (old_v & ~m);
    endfunction

    assign acc = i_wr ? urm_pkg::ACC_WRITE
               : (i_rd ? urm_pkg::ACC_READ : urm_pkg::ACC_IDLE);
    assign unlock = efr_q[urm_pkg::EFR_UNLOCK_BIT];
    assign enh_view = (lcr_q == urm_pkg::LCR_ENH_CODE);
    assign div_view = lcr_q[urm_pkg::LCR_DIV_EN_BIT] && !enh_view;
    assign id_view = div_view && (dll_q == urm_pkg::ZERO_BYTE)
                   && (dlm_q == urm_pkg::ZERO_BYTE);
    assign rx_pop = (acc == urm_pkg::ACC_READ) && !enh_view
                  && !div_view && (i_addr == urm_pkg::ADDR_DATA);
    assign rx_clr = (acc == urm_pkg::ACC_WRITE) && !enh_view
                  && (i_addr == urm_pkg::ADDR_ISR) && i_wdata[1];

    urm_rxq u_rxq (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_clr(rx_clr),
        .i_push(i_rx_push),
        .i_word(i_rx_word),
        .i_pop(rx_pop),
        .o_head(head),
        .o_count(fill)
    );

    // ------------------------------------------------------------
    // Status and interrupt logic
    // ------------------------------------------------------------
    always_comb begin
        case (fcr_q[7:6])
            2'b00: trig = urm_pkg::TRIG_L0;
            2'b01: trig = urm_pkg::TRIG_L1;
            2'b10: trig = urm_pkg::TRIG_L2;
            default: trig = urm_pkg::TRIG_L3;
        endcase
    end
    // Without FIFOs a single character counts as reaching the trigger.
    assign trig_hit = fcr_q[urm_pkg::FCR_FIFO_EN_BIT]
                    ? (fill >= trig) : (fill != '0);
    assign rx_src = ier_q[urm_pkg::IER_RX_BIT] && trig_hit;
    assign ls_src = ier_q[urm_pkg::IER_LS_BIT] && (line_status_reg[4:1] != 4'h0);
    assign tx_src = ier_q[urm_pkg::IER_TX_BIT] && i_tx_hold_empty;
    assign ms_src = ier_q[urm_pkg::IER_MS_BIT] && (dmsr_q != 4'h0);

    assign line_status_reg = {1'b0, i_tx_all_empty, i_tx_hold_empty,
                  (fill != '0) ? head.err : 3'b000, ovr_q,
                  fill != '0};
    assign modem_status_reg = {~m2_q.carrier_detect_n, ~m2_q.ring_indicator_n,
                  ~m2_q.dsr_n, ~m2_q.cts_n, dmsr_q};

    always_comb begin
        irq_status_reg = urm_pkg::ISR_NONE;
        if (ls_src) irq_status_reg[3:0] = urm_pkg::ISR_LS_CODE;
        else if (rx_src) irq_status_reg[3:0] = urm_pkg::ISR_RX_CODE;
        else if (tx_src) irq_status_reg[3:0] = urm_pkg::ISR_TX_CODE;
        else if (ms_src) irq_status_reg[3:0] = urm_pkg::ISR_MS_CODE;
        irq_status_reg[7:6] = {2{fcr_q[urm_pkg::FCR_FIFO_EN_BIT]}};
    end
    assign o_irq = ls_src || rx_src || tx_src || ms_src;

    // ------------------------------------------------------------
    // Register next state
    // ------------------------------------------------------------
    always_comb begin
        lcr_d = lcr_q;
        ier_d = ier_q;
        fcr_d = fcr_q;
        mcr_d = mcr_q;
        dll_d = dll_q;
        dlm_d = dlm_q;
        frac_d = frac_q;
        efr_d = efr_q;
        spr_d = spr_q;
        resume_char_one_reg_d = resume_char_one_reg_q;
        resume_char_two_reg_d = resume_char_two_reg_q;
        pause_char_one_reg_d = pause_char_one_reg_q;
        pause_char_two_reg_d = pause_char_two_reg_q;
        rdata_d = rdata_q;
        ovr_d = ovr_q;
        // Change flags: a fresh edge wins over the clearing read.
        dmsr_d = dmsr_q;
        if (acc == urm_pkg::ACC_READ && !enh_view
            && i_addr == urm_pkg::ADDR_MSR) dmsr_d = 4'h0;
        dmsr_d = dmsr_d | {m2_q.carrier_detect_n != m3_q.carrier_detect_n,
                           m2_q.ring_indicator_n != m3_q.ring_indicator_n,
                           m2_q.dsr_n != m3_q.dsr_n,
                           m2_q.cts_n != m3_q.cts_n};
        if (acc == urm_pkg::ACC_READ && !enh_view
            && i_addr == urm_pkg::ADDR_LSR) ovr_d = 1'b0;
        if (i_rx_push && fill == 5'(urm_pkg::RX_DEPTH)) ovr_d = 1'b1;
        if (acc == urm_pkg::ACC_WRITE) begin
            if (i_addr == urm_pkg::ADDR_LCR) begin
                lcr_d = i_wdata;
            end else if (enh_view) begin
                if (i_addr == urm_pkg::ADDR_ISR) efr_d = i_wdata;
                else if (i_addr == urm_pkg::ADDR_MCR) resume_char_one_reg_d = i_wdata;
                else if (i_addr == urm_pkg::ADDR_LSR) resume_char_two_reg_d = i_wdata;
                else if (i_addr == urm_pkg::ADDR_MSR) pause_char_one_reg_d = i_wdata;
                else if (i_addr == urm_pkg::ADDR_SPR) pause_char_two_reg_d = i_wdata;
            end else if (div_view && i_addr == urm_pkg::ADDR_DATA) begin
                dll_d = i_wdata;
            end else if (div_view && i_addr == urm_pkg::ADDR_IER) begin
                dlm_d = i_wdata;
            end else if (div_view && i_addr == urm_pkg::ADDR_ISR) begin
                if (unlock) frac_d = i_wdata & urm_pkg::FRAC_MASK;
            end else if (i_addr == urm_pkg::ADDR_IER) begin
                ier_d = merge_locked(ier_q, i_wdata,
                                     urm_pkg::IER_BASE_MASK, unlock);
            end else if (i_addr == urm_pkg::ADDR_ISR) begin
                fcr_d = merge_locked(fcr_q, i_wdata,
                                     urm_pkg::FCR_BASE_MASK, unlock);
            end else if (i_addr == urm_pkg::ADDR_MCR) begin
                mcr_d = merge_locked(mcr_q, i_wdata,
                                     urm_pkg::MCR_BASE_MASK, unlock);
            end else if (i_addr == urm_pkg::ADDR_SPR) begin
                spr_d = i_wdata;
            end
        end
        if (acc == urm_pkg::ACC_READ) begin
            if (i_addr == urm_pkg::ADDR_LCR) rdata_d = lcr_q;
            else if (enh_view) begin
                if (i_addr == urm_pkg::ADDR_ISR) rdata_d = efr_q;
                else if (i_addr == urm_pkg::ADDR_MCR) rdata_d = resume_char_one_reg_q;
                else if (i_addr == urm_pkg::ADDR_LSR) rdata_d = resume_char_two_reg_q;
                else if (i_addr == urm_pkg::ADDR_MSR) rdata_d = pause_char_one_reg_q;
                else if (i_addr == urm_pkg::ADDR_SPR) rdata_d = pause_char_two_reg_q;
                else rdata_d = urm_pkg::ZERO_BYTE;
            end else if (id_view && i_addr == urm_pkg::ADDR_DATA) begin
                rdata_d = urm_pkg::REVISION_CODE;
            end else if (id_view && i_addr == urm_pkg::ADDR_IER) begin
                rdata_d = urm_pkg::DEVICE_IDENT;
            end else if (div_view && i_addr == urm_pkg::ADDR_DATA) begin
                rdata_d = dll_q;
            end else if (div_view && i_addr == urm_pkg::ADDR_IER) begin
                rdata_d = dlm_q;
            end else if (div_view && i_addr == urm_pkg::ADDR_ISR
                         && unlock) begin
                rdata_d = frac_q;
            end else if (i_addr == urm_pkg::ADDR_DATA) rdata_d = head.data;
            else if (i_addr == urm_pkg::ADDR_IER) rdata_d = ier_q;
            else if (i_addr == urm_pkg::ADDR_ISR) rdata_d = irq_status_reg;
            else if (i_addr == urm_pkg::ADDR_MCR) rdata_d = mcr_q;
            else if (i_addr == urm_pkg::ADDR_LSR) rdata_d = line_status_reg;
            else if (i_addr == urm_pkg::ADDR_MSR) rdata_d = modem_status_reg;
            else rdata_d = spr_q;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            lcr_q <= urm_pkg::LCR_RESET;
            {ier_q, fcr_q, mcr_q, dll_q, dlm_q, frac_q} <= '0;
            {efr_q, spr_q, resume_char_one_reg_q, resume_char_two_reg_q, pause_char_one_reg_q, pause_char_two_reg_q} <= '0;
            rdata_q <= '0;
            dmsr_q <= '0;
            ovr_q <= 1'b0;
        end else begin
            lcr_q <= lcr_d;
            ier_q <= ier_d;
            fcr_q <= fcr_d;
            mcr_q <= mcr_d;
            dll_q <= dll_d;
            dlm_q <= dlm_d;
            frac_q <= frac_d;
            efr_q <= efr_d;
            spr_q <= spr_d;
            resume_char_one_reg_q <= resume_char_one_reg_d;
            resume_char_two_reg_q <= resume_char_two_reg_d;
            pause_char_one_reg_q <= pause_char_one_reg_d;
            pause_char_two_reg_q <= pause_char_two_reg_d;
            rdata_q <= rdata_d;
            dmsr_q <= dmsr_d;
            ovr_q <= ovr_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_tx_data = i_wdata;
    assign o_tx_load = (acc == urm_pkg::ACC_WRITE) && !enh_view
                     && !div_view && (i_addr == urm_pkg::ADDR_DATA);
    assign o_divisor = {dlm_q, dll_q};
    assign o_frac = frac_q;
    assign o_efr = efr_q;
    assign o_lcr = lcr_q;
    assign o_mcr = mcr_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_fifo_fill;
        fcr_q[urm_pkg::FCR_FIFO_EN_BIT] && ier_q[urm_pkg::IER_RX_BIT]
            && (fill >= trig);
    endsequence
    chk_rx_trig_irq: assert property (
        s_fifo_fill |-> o_irq) else $error("trigger reached, no irq");
    chk_rx_isr_code: assert property (
        s_fifo_fill and !ls_src |-> irq_status_reg[3:0] == urm_pkg::ISR_RX_CODE)
        else $error("isr code wrong at trigger");
    chk_rx_drop_clear: assert property (
        fcr_q[urm_pkg::FCR_FIFO_EN_BIT] && (fill < trig) |-> !rx_src)
        else $error("rx source held below trigger");
    chk_ready_set: assert property (
        i_rx_push && fill == '0 && !rx_clr |=> line_status_reg[0])
        else $error("ready not set on push");
    chk_ready_hold: assert property (
        line_status_reg[0] && !$past(line_status_reg[0]) |-> $past(i_rx_push))
        else $error("ready rose without push");
    chk_mask_block: assert property (
        ier_q[3:0] == 4'h0 |-> !o_irq)
        else $error("irq with all masks clear");
    chk_lock_hold: assert property (
        !unlock && i_wr |=> ier_q[7:4] == $past(ier_q[7:4]))
        else $error("locked bits changed");
    chk_scratch_keep: assert property (
        i_wr && i_addr == urm_pkg::ADDR_SPR && !enh_view
        |=> spr_q == $past(i_wdata))
        else $error("scratch write lost");
    chk_div_view: assert property (
        i_wr && i_addr == urm_pkg::ADDR_DATA && div_view
        |=> dll_q == $past(i_wdata))
        else $error("divisor low not written");
endmodule
`default_nettype wire

// >>> urm_line_model.sv
// Serial-side partner model: receive pushes, transmitter levels, modem pins.
`timescale 1ns/1ps
`default_nettype none
module urm_line_model (
    input wire logic i_clk,
    output logic o_push,
    output var urm_pkg::urm_rx_word_t o_word,
    output logic o_hold_empty,
    output logic o_all_empty,
    output var urm_pkg::urm_modem_t o_modem_n
);
    // ----------------------------------------------------------------
    // Line activity
    // ----------------------------------------------------------------
    initial begin
        o_push = 1'b0;
        o_word = 11'h7ff;
        o_hold_empty = 1'b0;
        o_all_empty = 1'b0;
        o_modem_n = 4'hf;
    end
    // The word is inverted once the push is over, so stale data is useless.
    task automatic push(input logic [10:0] w);
        @(negedge i_clk);
        o_word = w;
        o_push = 1'b1;
        @(negedge i_clk);
        o_push = 1'b0;
        o_word = ~w;
    endtask
    task automatic set_tx(input logic h, input logic a);
        @(negedge i_clk);
        o_hold_empty = h;
        o_all_empty = a;
    endtask
    task automatic set_modem(input logic [3:0] m);
        @(negedge i_clk);
        o_modem_n = m;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the UART channel register map.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic i_clk = 0, i_rst_n = 0, i_rd = 0, i_wr = 0;
    logic [2:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, o_tx_data, o_frac, o_efr, o_lcr, o_mcr;
    logic o_irq, o_tx_load, rx_push, hold_e, all_e;
    logic [15:0] o_divisor;
    urm_pkg::urm_rx_word_t rx_word;
    urm_pkg::urm_modem_t modem_n;
    int failures = 0, n_checks = 0, seed = 32'h09a7, tl[4] = '{1, 4, 8, 14};
    logic [10:0] q[$];
    logic [7:0] a, b, fc[4];
    always #50 i_clk = ~i_clk;
    urm_line_model line_u (.i_clk(i_clk), .o_push(rx_push), .o_word(rx_word),
        .o_hold_empty(hold_e), .o_all_empty(all_e), .o_modem_n(modem_n));
    urm_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_irq(o_irq), .i_rx_push(rx_push), .i_rx_word(rx_word),
        .i_tx_hold_empty(hold_e), .i_tx_all_empty(all_e),
        .i_modem_n(modem_n), .o_tx_data(o_tx_data), .o_tx_load(o_tx_load),
        .o_divisor(o_divisor), .o_frac(o_frac), .o_efr(o_efr),
        .o_lcr(o_lcr), .o_mcr(o_mcr));
    // ----------------------------------------------------------------
    // Host bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        @(negedge i_clk);
        i_addr = ad;
        i_wdata = d;
        i_wr = 1;
        @(negedge i_clk);
        i_wr = 0;
    endtask
    // One spare cycle after the strobe so either read latency is covered.
    task automatic rc(input logic [2:0] ad, input logic [7:0] e, string nm);
        @(negedge i_clk);
        i_addr = ad;
        i_rd = 1;
        @(negedge i_clk);
        i_rd = 0;
        @(negedge i_clk);
        `CHK(nm, e, o_rdata)
    endtask
    task automatic chk_lsr();
        rc(3'h5, {1'b0, all_e, hold_e,
            ((q.size() != 0) ? q[0][2:0] : 3'b000),
            1'b0, 1'(q.size() != 0)}, "lsr_read");
        `CHK("lsr_ready", q.size() != 0, o_rdata[0])
        if (q.size() != 0) begin
            `CHK("lsr", {1'b0, all_e, hold_e, q[0][2:0], 1'b0},
                o_rdata[7:1])
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_clk);
        failures++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1;
        repeat (3) @(negedge i_clk);
        rc(3'h3, 8'h00, "lcr_rst");
        `CHK("lcr_out", 8'h00, o_lcr)
        wr(3'h1, 8'hff);
        rc(3'h1, 8'h0f, "ier_lock");
        wr(3'h4, 8'hef);
        rc(3'h4, 8'h0f, "mcr_lock");
        `CHK("mcr_out", 8'h0f, o_mcr)
        wr(3'h1, 8'h00);
        rc(3'h6, 8'h00, "msr_idle");
        a = 8'($random(seed));
        wr(3'h7, a);
        rc(3'h7, a, "scratch");
        rc(3'h3, 8'h00, "lcr_kept");
        b = (8'($random(seed)) & 8'hf6) | 8'h04;
        line_u.set_modem(b[3:0]);
        repeat (4) @(negedge i_clk);
        rc(3'h6, {~b[3:0], b[3:0] ^ 4'hf}, "msr_change");
        rc(3'h6, {~b[3:0], 4'h0}, "msr_clear");
        wr(3'h3, 8'h80);
        a = 8'($random(seed)) | 8'h01;
        b = 8'($random(seed));
        wr(3'h0, a);
        wr(3'h1, b);
        rc(3'h0, a, "div_low");
        rc(3'h1, b, "div_high");
        `CHK("divisor", {b, a}, o_divisor)
        wr(3'h2, 8'hff);
        rc(3'h2, 8'h01, "frac_lock");
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        rc(3'h0, urm_pkg::REVISION_CODE, "rev");
        rc(3'h1, urm_pkg::DEVICE_IDENT, "ident");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        rc(3'h2, 8'h10, "efr");
        `CHK("efr_out", 8'h10, o_efr)
        for (int i = 0; i < 4; i++) begin
            fc[i] = 8'($random(seed));
            wr(3'(i + 4), fc[i]);
        end
        for (int i = 0; i < 4; i++) rc(3'(i + 4), fc[i], "flow_char");
        wr(3'h3, 8'h80);
        wr(3'h2, 8'hff);
        rc(3'h2, 8'h3f, "frac");
        `CHK("frac_out", 8'h3f, o_frac)
        wr(3'h3, 8'h03);
        `CHK("lcr_out", 8'h03, o_lcr)
        // Every trigger level is filled to the mark and drained again.
        for (int lv = 0; lv < 4; lv++) begin
            wr(3'h2, {2'(lv), 6'h03});
            wr(3'h1, 8'h01);
            for (int k = 0; k < tl[lv]; k++) begin
                q.push_back(11'($random(seed)));
                line_u.push(q[$]);
                `CHK("irq_fill", 1'(q.size() >= tl[lv]), o_irq)
                chk_lsr();
            end
            rc(3'h2, 8'hc4, "isr_rx");
            wr(3'h1, 8'h00);
            `CHK("irq_mask", 1'b0, o_irq)
            rc(3'h2, 8'hc1, "isr_none");
            wr(3'h1, 8'h01);
            while (q.size() > 0) begin
                a = q[0][10:3];
                void'(q.pop_front());
                rc(3'h0, a, "rx_data");
                `CHK("irq_drain", 1'(q.size() >= tl[lv]), o_irq)
                chk_lsr();
            end
        end
        @(negedge i_clk);
        i_addr = 3'h0;
        i_wdata = fc[0];
        i_wr = 1;
        #10 `CHK("tx_load", 1'b1, o_tx_load)
        `CHK("tx_data", fc[0], o_tx_data)
        @(negedge i_clk);
        i_wr = 0;
        #10 `CHK("tx_idle", 1'b0, o_tx_load)
        line_u.set_tx(1'b1, 1'b1);
        rc(3'h5, 8'h60, "lsr_tx");
        wr(3'h1, 8'h02);
        `CHK("irq_tx", 1'b1, o_irq)
        rc(3'h2, 8'hc2, "isr_tx");
        wr(3'h1, 8'h00);
        `CHK("irq_off", 1'b0, o_irq)
        wrap_up();
    end
endmodule
`default_nettype wire
